// ### shared/ccw_pkg.sv
// Package for the card-change interrupt config and window enable block.
// Assumes byte-wide socket register port and 100 MHz bus clock.
package ccw_pkg;

    localparam int         CCW_ADDR_W       = 12;
    localparam int         CCW_DATA_W       = 8;
    localparam int         CCW_NUM_SRC      = 4;
    localparam int         CCW_NUM_IRQ      = 16;
    localparam int         CCW_NUM_MEMWIN   = 5;
    localparam int         CCW_NUM_IOWIN    = 2;

    // Register offsets in the socket register space
    localparam logic [11:0] CCW_OFF_IRQ_CFG = 12'h805;
    localparam logic [11:0] CCW_OFF_WIN_EN  = 12'h806;

    // Reset values
    localparam logic [7:0] CCW_IRQ_CFG_RST  = 8'h00;
    localparam logic [7:0] CCW_WIN_EN_RST   = 8'h00;
    localparam logic [7:0] CCW_RDATA_NONE   = 8'h00;

    // Field positions of the interrupt config byte
    localparam int         CCW_ROUTE_MSB    = 7;
    localparam int         CCW_ROUTE_LSB    = 4;
    localparam int         CCW_SRC_MSB      = 3;
    localparam int         CCW_SRC_LSB      = 0;
    localparam int         CCW_SRC_DETECT   = 3;
    localparam int         CCW_SRC_READY    = 2;
    localparam int         CCW_SRC_BATLOW   = 1;
    localparam int         CCW_SRC_BATDEAD  = 0;

    // Field positions of the window enable byte
    localparam int         CCW_IOWIN1_BIT   = 7;
    localparam int         CCW_IOWIN0_BIT   = 6;
    localparam int         CCW_WIN_RSVD_BIT = 5;
    localparam int         CCW_MEMWIN_MSB   = 4;
    localparam logic [7:0] CCW_WIN_WR_MASK  = 8'hDF;

    // Routing codes
    localparam logic [3:0] CCW_ROUTE_NONE   = 4'h0;
    localparam logic [3:0] CCW_ROUTE_SMI    = 4'h2;

    // Card side pins, already in bus clock domain after sync
    typedef struct packed {
        logic cd1_n;
        logic cd2_n;
        logic ready;
        logic bat_warn;
        logic card_change;
    } ccw_card_pins_t;

    // Host cycle aimed at a card window
    typedef struct packed {
        logic       valid;
        logic       is_io;
        logic [2:0] win;
    } ccw_cycle_t;

    // Routed interrupt destinations
    typedef struct packed {
        logic        pci;
        logic        smi;
        logic [15:0] irq;
    } ccw_irq_dest_t;

endpackage : ccw_pkg

// ### src/ccw_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent level; no bus coherency.
`timescale 1ns/1ps
module ccw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] rst_val_in,
    // Data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta;

    // First stage read only by the second stage
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            meta  <= rst_val_in;
            q_out <= rst_val_in;
        end
        else
        begin
            meta  <= d_in;
            q_out <= meta;
        end
    end

endmodule : ccw_sync

// ### src/ccw_flags.sv
// Status-change flags: detect card events, gate by source enables.
// Assumes synced pins and a one-cycle clear pulse per flag.
`timescale 1ns/1ps
module ccw_flags
    import ccw_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   srst_in,
    // Card pins, synchronised
    input  wire ccw_pkg::ccw_card_pins_t pins_in,
    // Enables and software clears
    input  wire logic [3:0]             src_en_in,
    input  wire logic [3:0]             clear_in,
    // Flags
    output logic      [3:0]             flags_out
);
    ccw_card_pins_t prev;
    logic [3:0]     event_hit;
    logic [3:0]     next_flags;

    assign event_hit[CCW_SRC_DETECT]  = (pins_in.cd1_n != prev.cd1_n)
                                      | (pins_in.cd2_n != prev.cd2_n);
    assign event_hit[CCW_SRC_READY]   = pins_in.ready & ~prev.ready;
    assign event_hit[CCW_SRC_BATLOW]  = pins_in.bat_warn;
    assign event_hit[CCW_SRC_BATDEAD] = pins_in.card_change;

    // Set beats clear; disabled source forces zero
    assign next_flags = src_en_in
                      & ((flags_out & ~clear_in) | event_hit);

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            // Track pins in reset so release shows no false edge
            prev      <= pins_in;
            flags_out <= '0;
        end
        else
        begin
            prev      <= pins_in;
            flags_out <= next_flags;
        end
    end

endmodule : ccw_flags

// ### src/ccw_top.sv
// Card-change interrupt config and window enable registers.
// Assumes socket register strobes on clk_in, window hit from a decoder.
`timescale 1ns/1ps
module ccw_top
    import ccw_pkg::*;
(
    // Clock and global reset
    input  wire logic                   clk_in,
    input  wire logic                   srst_in,
    // Bus reset pin and power event enable
    input  wire logic                   bus_reset_pin_n_in,
    input  wire logic                   pme_enable_in,
    // Socket register port
    input  wire logic [ccw_pkg::CCW_ADDR_W-1:0] reg_addr_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    input  wire logic [ccw_pkg::CCW_DATA_W-1:0] reg_wdata_in,
    output logic      [ccw_pkg::CCW_DATA_W-1:0] reg_rdata_out,
    // Routing controls from neighbouring registers
    input  wire logic                   diag_route_ctrl_in,
    input  wire logic                   change_irq_pci_route_in,
    // Card pins
    input  wire ccw_pkg::ccw_card_pins_t card_pins_in,
    // Status-change flags, cleared by the status register logic
    input  wire logic [3:0]             flag_clear_in,
    output logic      [3:0]             card_status_change_out,
    // Interrupt destinations
    output ccw_pkg::ccw_irq_dest_t      irq_dest_out,
    // Host cycles to card windows
    input  wire ccw_pkg::ccw_cycle_t    cycle_in,
    output logic                        cycle_ack_out
);
    // Config byte fields and window enable byte
    logic [3:0]     change_irq_route_select;
    logic [3:0]     src_en;
    logic [7:0]     window_enable;

    // Pin synchronisation
    ccw_card_pins_t pins_sync;
    logic           bus_rst_n_sync;
    logic           bus_rst;

    // Decode
    logic           sel_cfg;
    logic           sel_win;
    logic           wr_cfg;
    logic           wr_win;
    logic           mask_clear;
    logic           route_clear;
    logic [3:0]     route_rst;
    logic [3:0]     route_wr;
    logic [7:0]     cfg_byte;
    logic [7:0]     next_rdata;
    logic           any_flag;
    ccw_irq_dest_t  next_dest;
    logic [7:0]     win_hit_en;
    logic           next_ack;
    logic [4:0]     mem_en;
    logic [1:0]     io_en;

    // Empty socket levels; avoids a false detect edge after reset
    localparam ccw_card_pins_t PINS_IDLE = '{cd1_n: 1'b1, cd2_n: 1'b1,
                                            default: 1'b0};

    ccw_sync #(
        .W          ($bits(ccw_card_pins_t))
    ) u_pin_sync (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .rst_val_in (PINS_IDLE),
        .d_in       (card_pins_in),
        .q_out      (pins_sync)
    );

    // Bus reset pin is asynchronous to the bus clock
    ccw_sync #(
        .W          (1)
    ) u_rst_sync (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .rst_val_in (1'b0), // Released: first access after reset lands
        .d_in       (~bus_reset_pin_n_in),
        .q_out      (bus_rst)
    );
    assign bus_rst_n_sync = ~bus_rst;

    assign sel_cfg = (reg_addr_in == CCW_OFF_IRQ_CFG);
    assign sel_win = (reg_addr_in == CCW_OFF_WIN_EN);
    assign wr_cfg  = reg_wr_in & sel_cfg;
    assign wr_win  = reg_wr_in & sel_win;

    // Source enables survive the bus reset while power events are enabled
    assign mask_clear  = srst_in
                       | (~bus_rst_n_sync & ~pme_enable_in);
    assign route_clear = srst_in | ~bus_rst_n_sync;
    assign route_rst   = CCW_IRQ_CFG_RST[CCW_ROUTE_MSB:CCW_ROUTE_LSB];
    assign route_wr    = reg_wdata_in[CCW_ROUTE_MSB:CCW_ROUTE_LSB];

    always_ff @(posedge clk_in)
    begin
        if (route_clear)
            change_irq_route_select <= route_rst;
        else if (wr_cfg)
            change_irq_route_select <= route_wr;
    end

    always_ff @(posedge clk_in)
    begin
        if (mask_clear)
            src_en <= CCW_IRQ_CFG_RST[CCW_SRC_MSB:CCW_SRC_LSB];
        else if (wr_cfg)
            src_en <= reg_wdata_in[CCW_SRC_MSB:CCW_SRC_LSB];
    end

    always_ff @(posedge clk_in)
    begin
        if (route_clear)
            window_enable <= CCW_WIN_EN_RST;
        else if (wr_win)
            window_enable <= reg_wdata_in & CCW_WIN_WR_MASK;
    end

    assign cfg_byte   = {change_irq_route_select, src_en};
    assign next_rdata = sel_cfg ? cfg_byte
                      : sel_win ? window_enable
                      : CCW_RDATA_NONE;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            reg_rdata_out <= CCW_RDATA_NONE;
        else if (reg_rd_in)
            reg_rdata_out <= next_rdata;
    end

    // Each bit gates its own source
    ccw_flags u_flags (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .pins_in    (pins_sync),
        .src_en_in  (src_en),
        .clear_in   (flag_clear_in),
        .flags_out  (card_status_change_out)
    );

    assign any_flag = |card_status_change_out;

    // Routing; unlisted codes fall through to the IRQ of the same number
    always_comb
    begin
        next_dest = '0;
        if (change_irq_route_select == CCW_ROUTE_NONE)
            next_dest.pci = any_flag
                & (diag_route_ctrl_in | change_irq_pci_route_in);
        else if (change_irq_route_select == CCW_ROUTE_SMI)
            next_dest.smi = any_flag;
        else
            next_dest.irq[change_irq_route_select] = any_flag;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            irq_dest_out <= '0;
        else
            irq_dest_out <= next_dest;
    end

    // Window hit gating
    assign mem_en = window_enable[CCW_MEMWIN_MSB:0];
    assign io_en  = {window_enable[CCW_IOWIN1_BIT],
                     window_enable[CCW_IOWIN0_BIT]};

    generate
        for (genvar i = 0; i < $bits(win_hit_en); i++)
        begin : g_win
            if (i < CCW_NUM_MEMWIN)
                assign win_hit_en[i] = cycle_in.is_io ? (i < CCW_NUM_IOWIN
                                       ? io_en[i % CCW_NUM_IOWIN] : 1'b0)
                                     : mem_en[i];
            else
                assign win_hit_en[i] = 1'b0;
        end
    endgenerate

    // Out-of-range windows are never acknowledged
    assign next_ack = cycle_in.valid
                    & win_hit_en[cycle_in.win];

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            cycle_ack_out <= 1'b0;
        else
            cycle_ack_out <= next_ack;
    end

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    property p_win_rsvd;
        window_enable[CCW_WIN_RSVD_BIT] == 1'b0;
    endproperty
    a_win_rsvd: assert property (p_win_rsvd)
        else $error("reserved window bit set");

    property p_win_write;
        wr_win & ~route_clear
            |=> window_enable == ($past(reg_wdata_in) & CCW_WIN_WR_MASK);
    endproperty
    a_win_write: assert property (p_win_write)
        else $error("window enable write lost");

    property p_ack_disabled;
        cycle_in.valid & ~win_hit_en[cycle_in.win] |=> ~cycle_ack_out;
    endproperty
    a_ack_disabled: assert property (p_ack_disabled)
        else $error("ack to disabled window");

    property p_mem_ack;
        cycle_in.valid & ~cycle_in.is_io & (cycle_in.win < CCW_NUM_MEMWIN)
            & mem_en[cycle_in.win] |=> cycle_ack_out;
    endproperty
    a_mem_ack: assert property (p_mem_ack)
        else $error("enabled memory window not acked");

    property p_cfg_readback;
        wr_cfg & ~route_clear & ~mask_clear ##1 reg_rd_in & sel_cfg
            |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("config byte readback mismatch");

    property p_flag_masked;
        ~src_en[CCW_SRC_DETECT] |=> ~card_status_change_out[CCW_SRC_DETECT];
    endproperty
    a_flag_masked: assert property (p_flag_masked)
        else $error("flag set while source disabled");

    property p_pci_diag;
        change_irq_route_select == CCW_ROUTE_NONE & diag_route_ctrl_in
            & any_flag |=> irq_dest_out.pci;
    endproperty
    a_pci_diag: assert property (p_pci_diag)
        else $error("pci route missing");

    property p_pci_off;
        change_irq_route_select == CCW_ROUTE_NONE & ~diag_route_ctrl_in
            & ~change_irq_pci_route_in |=> ~irq_dest_out.pci;
    endproperty
    a_pci_off: assert property (p_pci_off)
        else $error("pci route without route bit");

    property p_smi;
        change_irq_route_select == CCW_ROUTE_SMI & any_flag
            |=> irq_dest_out.smi & irq_dest_out.irq == 16'h0000;
    endproperty
    a_smi: assert property (p_smi)
        else $error("smi route wrong");

    property p_irq_drop;
        ~any_flag |=> irq_dest_out == '0;
    endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("interrupt held without flag");

    property p_pme_keep;
        ~srst_in & ~bus_rst_n_sync & pme_enable_in & ~wr_cfg
            |=> src_en == $past(src_en);
    endproperty
    a_pme_keep: assert property (p_pme_keep)
        else $error("enables lost on bus reset with pme");

    property p_pci_route;
        change_irq_route_select == CCW_ROUTE_NONE & ~diag_route_ctrl_in
            & change_irq_pci_route_in & any_flag |=> irq_dest_out.pci;
    endproperty
    a_pci_route: assert property (p_pci_route)
        else $error("pci route bit ignored");

    property p_irq_line;
        change_irq_route_select != CCW_ROUTE_NONE
            & change_irq_route_select != CCW_ROUTE_SMI & any_flag
            |=> $onehot(irq_dest_out.irq) & ~irq_dest_out.smi
                & ~irq_dest_out.pci;
    endproperty
    a_irq_line: assert property (p_irq_line)
        else $error("legacy line route wrong");

    // Bus reset alone; global reset is outside the checks
    property p_win_clear;
        route_clear |=> window_enable == CCW_WIN_EN_RST;
    endproperty
    a_win_clear: assert property (p_win_clear)
        else $error("window enable kept over reset");

    c_ack:   cover property (cycle_in.valid ##1 cycle_ack_out);
    c_irq:   cover property (any_flag ##1 |irq_dest_out.irq);
    c_smi:   cover property (irq_dest_out.smi);
    c_pme:   cover property (~bus_rst_n_sync & pme_enable_in & |src_en);
    c_pci:   cover property (irq_dest_out.pci);

endmodule : ccw_top

// ### sim/ccw_card_model.sv
// Card-side model: detect pins, ready and battery levels of a 16-bit card.
// Assumes the bench requests insertion and levels; pins move after edges.
`timescale 1ns/1ps
module ccw_card_model
    import ccw_pkg::*;
(
    // Clock
    input  wire logic               clk_in,
    // Requests from the bench: {ready, bat_warn, card_change}
    input  wire logic               insert_in,
    input  wire logic [2:0]         lvl_in,
    // Card pins
    output ccw_pkg::ccw_card_pins_t pins_out
);
    logic seat;

    // Second detect pin mates a cycle late, as in a real socket
    always_ff @(posedge clk_in)
    begin
        seat     <= insert_in;
        pins_out <= {~insert_in, ~seat, lvl_in};
    end
endmodule : ccw_card_model

// ### sim/testbench.sv
// Bench for the card-change interrupt config and window enable block.
// Assumes the card model drives the pins; results checked from a queue.
`timescale 1ns/1ps
module testbench;
    import ccw_pkg::*;
    typedef struct packed
    {
        logic [1:0]  kind;
        logic [21:0] val;
    } ccw_note_t;

    logic clk_in, srst_in, bus_n, pme, wr, rd, diag, proute, snap, insert;
    logic [11:0] addr;
    logic [7:0]  wdata, rdata, en;
    logic [3:0]  fclr, flags, code;
    logic [2:0]  lvl;
    logic        ack, e, rd_q, ack_q, snap_q;
    logic [21:0] got;
    logic [17:0] dx;
    logic [31:0] lfsr;
    ccw_card_pins_t pins;
    ccw_irq_dest_t  dest;
    ccw_cycle_t     cyc;
    ccw_note_t      notes[$];
    ccw_note_t      note;
    string          kname [3] = '{"rdata", "ack", "status"};
    int             fail_count, check_count, i, j;

    ccw_card_model u_card (.clk_in(clk_in), .insert_in(insert),
        .lvl_in(lvl), .pins_out(pins));

    ccw_top u_dut (.clk_in(clk_in), .srst_in(srst_in),
        .bus_reset_pin_n_in(bus_n), .pme_enable_in(pme),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .diag_route_ctrl_in(diag), .change_irq_pci_route_in(proute),
        .card_pins_in(pins), .flag_clear_in(fclr),
        .card_status_change_out(flags), .irq_dest_out(dest),
        .cycle_in(cyc), .cycle_ack_out(ack));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [17:0] dest_of(input logic [3:0] c,
        input logic dg, input logic pr);
        logic [17:0] d;
        d = 18'h0;
        if (c == 4'h0)
            d[17] = dg | pr;
        else if (c == 4'h2)
            d[16] = 1'h1;
        else
            d[c] = 1'h1;
        return d;
    endfunction : dest_of

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask : idle

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clk_in);
        wr    <= 1'h0;
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, input logic [7:0] x);
        notes.push_back('{2'h0, {14'h0, x}});
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clk_in);
        rd   <= 1'h0;
    endtask : reg_rd

    task automatic host_cycle(input logic io, input logic [2:0] w,
        input logic x);
        notes.push_back('{2'h1, {21'h0, x}});
        @(posedge clk_in);
        cyc <= '{1'h1, io, w};
        @(posedge clk_in);
        cyc.valid <= 1'h0;
    endtask : host_cycle

    task automatic expect_status(input logic [3:0] f, input logic [17:0] d);
        notes.push_back('{2'h2, {f, d}});
        @(posedge clk_in);
        snap <= 1'h1;
        @(posedge clk_in);
        snap <= 1'h0;
    endtask : expect_status

    // Bus reset pin or global reset, held well past the two sync flops
    task automatic reset_pulse(input logic bus);
        if (bus)
            bus_n <= 1'h0;
        else
            srst_in <= 1'h1;
        idle(4);
        bus_n   <= 1'h1;
        srst_in <= 1'h0;
        idle(3);
    endtask : reset_pulse

    task automatic finish_test();
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    initial
    begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end

    // Results land one cycle after the edge that took the request
    always @(posedge clk_in)
    begin
        rd_q   <= rd;
        ack_q  <= cyc.valid;
        snap_q <= snap;
    end

    always @(negedge clk_in)
        if (rd_q | ack_q | snap_q)
        begin
            note = notes.pop_front();
            got  = rd_q ? {14'h0, rdata} :
                   ack_q ? {21'h0, ack} : {flags, dest};
            check_count++;
            if (got !== note.val)
            begin
                fail_count++;
                $display("ERROR %s expected %h seen %h",
                    kname[note.kind], note.val, got);
            end
        end

    initial
    begin
        repeat (100000) @(posedge clk_in);
        fail_count++;
        finish_test();
    end

    initial
    begin
        {srst_in, bus_n, pme, wr, rd, diag, proute, snap, insert} = 9'h1C0;
        {addr, wdata, fclr, lvl, cyc} = '0;
        lfsr = 32'h8A27;
        idle(6);
        srst_in <= 1'h0;
        reg_rd(12'h805, 8'h00);
        reg_rd(12'h806, 8'h00);
        expect_status(4'h0, 18'h0);
        reg_wr(12'h807, 8'hFF);
        reg_rd(12'h807, 8'h00);
        reg_rd(12'h806, 8'h00);
        reg_wr(12'h805, 8'hA5);
        reg_rd(12'h805, 8'hA5);
        // Window enables: all set, all clear, then random patterns
        for (i = 0; i < 4; i++)
        begin
            en   = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : lfsr[7:0];
            lfsr = lfsr_next(lfsr);
            reg_wr(12'h806, en);
            reg_rd(12'h806, en & 8'hDF);
            for (j = 0; j < 16; j++)
            begin
                e = j[3] ? (j[2:0] < 2 && en[6 + j[0]])
                         : (j[2:0] < 5 && en[j[2:0]]);
                host_cycle(j[3], j[2:0], e);
            end
        end
        // Battery warning is a level source; walk every routing code
        lvl <= 3'h2;
        for (i = 0; i < 20; i++)
        begin
            code   = (i < 16) ? i[3:0] : 4'h0;
            diag   <= i[0];
            proute <= i[1];
            reg_wr(12'h805, {code, 4'h2});
            idle(4);
            dx = dest_of(code, i[0], i[1]);
            expect_status(4'h2, dx);
        end
        reg_wr(12'h805, 8'h20);
        idle(3);
        expect_status(4'h0, 18'h0);
        lvl <= 3'h0;
        reg_wr(12'h805, 8'h30);
        lvl <= 3'h4;
        idle(8);
        expect_status(4'h0, 18'h0);
        lvl <= 3'h0;
        reg_wr(12'h805, 8'h34);
        lvl <= 3'h4;
        idle(8);
        expect_status(4'h4, 18'h8);
        fclr <= 4'h4;
        idle(1);
        fclr <= 4'h0;
        idle(3);
        expect_status(4'h0, 18'h0);
        reg_wr(12'h805, 8'h38);
        insert <= 1'h1;
        idle(8);
        expect_status(4'h8, 18'h8);
        reg_wr(12'h805, 8'hA1);
        lvl <= 3'h5;
        idle(8);
        expect_status(4'h1, 18'h400);
        // Source enables survive the bus reset only with power events on
        pme <= 1'h1;
        reg_wr(12'h805, 8'h2F);
        reg_wr(12'h806, 8'h53);
        reset_pulse(1'h1);
        reg_rd(12'h805, 8'h0F);
        reg_rd(12'h806, 8'h00);
        pme <= 1'h0;
        reg_wr(12'h805, 8'h2F);
        reset_pulse(1'h1);
        reg_rd(12'h805, 8'h00);
        pme <= 1'h1;
        reg_wr(12'h805, 8'hFF);
        reset_pulse(1'h0);
        reg_rd(12'h805, 8'h00);
        idle(3);
        if (notes.size() != 0)
            fail_count++;
        finish_test();
    end
endmodule : testbench
